// file: core/psl_fault_encoder.sv
// priority encoder from rail fault flags to the 8-bit fault code
`timescale 1ns/100ps
module psl_fault_encoder (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_rst,
   input  wire psl_pkg::psl_fault_flags_t  i_faults,
   output logic                            o_valid,
   output logic [7:0]                      o_code
);
   // lowest set bit of a group overrides the earlier result
   function automatic logic [8:0] scan(input logic [7:0] bits, input logic [7:0] base,
                                       input logic [8:0] prev);
      logic [8:0] r;
      r = prev;
      for (int i = 7; i >= 0; i--) begin
         if (bits[i]) begin
            r = {1'b1, base + 8'(i)};
         end
      end
      return r;
   endfunction

   logic [7:0] sb_bits;
   logic [8:0] s9, s8, s7, s6, s5, s4, s3, s2, s1, s0;

   assign sb_bits = {2'h0, i_faults.standby_three_volt_rail[1], 4'h0,
                     i_faults.standby_three_volt_rail[0]};
   assign s9 = scan({3'h0, i_faults.system_three_volt_rail}, psl_pkg::CODE_SYS3, 9'h000);
   assign s8 = scan({3'h0, i_faults.system_five_volt_rail}, psl_pkg::CODE_SYS5, s9);
   assign s7 = scan({4'h0, i_faults.graphics_rail}, psl_pkg::CODE_GFX, s8);
   assign s6 = scan({4'h0, i_faults.processor_rail}, psl_pkg::CODE_PROC, s7);
   assign s5 = scan({2'h0, i_faults.core_one_eight_rail}, psl_pkg::CODE_CORE18, s6);
   assign s4 = scan({2'h0, i_faults.core_one_five_rail}, psl_pkg::CODE_CORE15, s5);
   assign s3 = scan(sb_bits, psl_pkg::CODE_STANDBY, s4);
   assign s2 = scan({2'h0, i_faults.batt_second}, psl_pkg::CODE_BATT_TWO, s3);
   assign s1 = scan({2'h0, i_faults.batt_first}, psl_pkg::CODE_BATT_ONE, s2);
   assign s0 = scan({3'h0, i_faults.adapter}, psl_pkg::CODE_ADAPTER, s1);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_code  <= 8'h00;
      end else begin
         o_valid <= s0[8];
         o_code  <= s0[7:0];
      end
   end

   AST_ADAPTER_OV_CODE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_faults.adapter[0] |=> (o_valid && o_code == psl_pkg::CODE_ADAPTER))
      else $error("adapter overvoltage not encoded as 10h");
endmodule

// file: core/psl_pkg.sv
// shared constants, types and timing for the power status indicator block
// How it works
// - charging with adapter: battery lamp steady orange
// - full charge with adapter: battery lamp steady green
// - low battery, system on: even orange blink
// - low, switch pressed on battery: orange flash
// - adapter present, no fault: supply lamp green
// - fault: supply lamp blinks orange code pattern
// - eight bit code, least significant bit first
// - adapter faults give codes 10h to 14h
// - battery faults give 20h-25h and 30h-35h
// - standby rail low gives 40h or 45h
// - one-five core rail gives 50h to 55h
// - one-eight core rail gives 60h to 65h
// - processor rail gives 70h to 73h
// - graphics rail gives 80h to 83h
// - five volt rail gives 90h to 94h
// - three volt rail gives A0h to A4h
package psl_pkg;

   // ==========================================================
   // timing
   localparam int CLK_MHZ         = 250;
   localparam int TICK_MS         = 100;
   localparam int TICK_CYCLES     = TICK_MS * 1000 * CLK_MHZ;
   localparam int START_MS        = 2000;
   localparam int ONE_MS          = 1000;
   localparam int ZERO_MS         = 500;
   localparam int GAP_MS          = 500;
   localparam int BLINK_MS        = 500;
   localparam int FLASH_ON_MS     = 100;
   localparam int FLASH_PERIOD_MS = 1000;

   localparam logic [7:0] START_TICKS        = 8'(START_MS / TICK_MS);
   localparam logic [7:0] ONE_TICKS          = 8'(ONE_MS / TICK_MS);
   localparam logic [7:0] ZERO_TICKS         = 8'(ZERO_MS / TICK_MS);
   localparam logic [7:0] GAP_TICKS          = 8'(GAP_MS / TICK_MS);
   localparam logic [7:0] BLINK_TICKS        = 8'(BLINK_MS / TICK_MS);
   localparam logic [7:0] FLASH_ON_TICKS     = 8'(FLASH_ON_MS / TICK_MS);
   localparam logic [7:0] FLASH_PERIOD_TICKS = 8'(FLASH_PERIOD_MS / TICK_MS);

   // ==========================================================
   // fault codes
   localparam int          CODE_W         = 8;
   localparam logic [2:0]  LAST_BIT       = 3'h7;
   localparam logic [7:0]  CODE_ADAPTER   = 8'h10;
   localparam logic [7:0]  CODE_BATT_ONE  = 8'h20;
   localparam logic [7:0]  CODE_BATT_TWO  = 8'h30;
   localparam logic [7:0]  CODE_STANDBY   = 8'h40;
   localparam int          STANDBY_CV_BIT = 5;
   localparam logic [7:0]  CODE_CORE15    = 8'h50;
   localparam logic [7:0]  CODE_CORE18    = 8'h60;
   localparam logic [7:0]  CODE_PROC      = 8'h70;
   localparam logic [7:0]  CODE_GFX       = 8'h80;
   localparam logic [7:0]  CODE_SYS5      = 8'h90;
   localparam logic [7:0]  CODE_SYS3      = 8'hA0;

   // ==========================================================
   // types
   typedef struct packed {
      logic [4:0] adapter;
      logic [5:0] batt_first;
      logic [5:0] batt_second;
      logic [1:0] standby_three_volt_rail;
      logic [5:0] core_one_five_rail;
      logic [5:0] core_one_eight_rail;
      logic [3:0] processor_rail;
      logic [3:0] graphics_rail;
      logic [4:0] system_five_volt_rail;
      logic [4:0] system_three_volt_rail;
   } psl_fault_flags_t;

   typedef struct packed {
      logic charging;
      logic full;
      logic batt_low;
      logic system_on;
      logic power_switch;
      logic adapter;
   } psl_cond_t;

   typedef struct packed {
      logic green;
      logic orange;
   } psl_lamp_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_BIT   = 2'b10,
      ST_GAP   = 2'b11
   } psl_blink_st_t;

endpackage

// file: core/psl_status_lamps.sv
// battery and external supply indicators with serial fault code blinker
`timescale 1ns/100ps
module psl_status_lamps #(
   parameter int TICK_CYCLES = psl_pkg::TICK_CYCLES
) (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_rst,
   input  wire psl_pkg::psl_cond_t         i_cond,
   input  wire psl_pkg::psl_fault_flags_t  i_faults,
   output psl_pkg::psl_lamp_t              o_battery_lamp,
   output psl_pkg::psl_lamp_t              o_external_supply_indicator,
   output logic                            o_fault_active,
   output logic [7:0]                      o_fault_code
);

   // ==========================================================
   // timebase and fault encoding
   logic       tick;
   logic       enc_valid;
   logic [7:0] enc_code;

   psl_tick_timer #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .o_tick    (tick)
   );

   psl_fault_encoder u_enc (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_faults  (i_faults),
      .o_valid   (enc_valid),
      .o_code    (enc_code)
   );

   // ==========================================================
   // slow phase generators
   logic [7:0] blink_cnt_reg;
   logic [7:0] blink_cnt_next;
   logic       blink_on_reg;
   logic       blink_on_next;
   logic [7:0] flash_cnt_reg;
   logic [7:0] flash_cnt_next;
   logic       blink_wrap;
   logic       flash_wrap;
   logic       flash_on;

   assign blink_wrap     = tick && (blink_cnt_reg == psl_pkg::BLINK_TICKS - 8'h01);
   assign blink_cnt_next = !tick ? blink_cnt_reg : (blink_wrap ? 8'h00 : blink_cnt_reg + 8'h01);
   assign blink_on_next  = blink_wrap ? !blink_on_reg : blink_on_reg;
   assign flash_wrap     = tick && (flash_cnt_reg == psl_pkg::FLASH_PERIOD_TICKS - 8'h01);
   assign flash_cnt_next = !tick ? flash_cnt_reg : (flash_wrap ? 8'h00 : flash_cnt_reg + 8'h01);
   assign flash_on       = (flash_cnt_reg < psl_pkg::FLASH_ON_TICKS);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         blink_cnt_reg <= 8'h00;
         blink_on_reg  <= 1'b0;
         flash_cnt_reg <= 8'h00;
      end else begin
         blink_cnt_reg <= blink_cnt_next;
         blink_on_reg  <= blink_on_next;
         flash_cnt_reg <= flash_cnt_next;
      end
   end

   // ==========================================================
   // battery indicator
   logic               chg_show;
   logic               full_show;
   logic               low_run;
   logic               low_press;
   logic               batt_dark;
   psl_pkg::psl_lamp_t batt_next;

   assign chg_show  = i_cond.charging && i_cond.adapter;
   assign full_show = i_cond.full && i_cond.adapter && !chg_show;
   assign low_run   = i_cond.batt_low && i_cond.system_on && !chg_show && !full_show;
   assign low_press = i_cond.batt_low && i_cond.power_switch && !i_cond.adapter
                      && !chg_show && !full_show && !low_run;
   assign batt_dark = !(chg_show || full_show || low_run || low_press);

   assign batt_next.green  = full_show;
   assign batt_next.orange = chg_show || (low_run && blink_on_reg) || (low_press && flash_on);

   // ==========================================================
   // fault latch
   logic       fault_reg;
   logic [7:0] code_reg;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         fault_reg <= 1'b0;
         code_reg  <= 8'h00;
      end else if (!fault_reg && enc_valid) begin
         fault_reg <= 1'b1;
         code_reg  <= enc_code;
      end
   end

   // ==========================================================
   // serial code blinker
   psl_pkg::psl_blink_st_t state_reg;
   psl_pkg::psl_blink_st_t state_next;
   logic [7:0]             elapsed_reg;
   logic [7:0]             elapsed_next;
   logic [2:0]             bit_idx_reg;
   logic [2:0]             bit_idx_next;
   logic [7:0]             dur_target;
   logic                   cur_bit;
   logic                   dur_done;

   assign cur_bit  = code_reg[bit_idx_reg];
   assign dur_done = tick && (elapsed_reg + 8'h01 >= dur_target);

   always_comb begin
      unique case (state_reg)
         psl_pkg::ST_IDLE:  dur_target = psl_pkg::START_TICKS;
         psl_pkg::ST_START: dur_target = psl_pkg::START_TICKS;
         psl_pkg::ST_BIT:   dur_target = cur_bit ? psl_pkg::ONE_TICKS : psl_pkg::ZERO_TICKS;
         psl_pkg::ST_GAP:   dur_target = psl_pkg::GAP_TICKS;
      endcase
   end

   always_comb begin
      state_next   = state_reg;
      bit_idx_next = bit_idx_reg;
      elapsed_next = tick ? elapsed_reg + 8'h01 : elapsed_reg;
      unique case (state_reg)
         psl_pkg::ST_IDLE: begin
            elapsed_next = 8'h00;
            if (fault_reg) begin
               state_next = psl_pkg::ST_START;
            end
         end
         psl_pkg::ST_START: begin
            if (dur_done) begin
               state_next   = psl_pkg::ST_BIT;
               elapsed_next = 8'h00;
               bit_idx_next = 3'h0;
            end
         end
         psl_pkg::ST_BIT: begin
            if (dur_done) begin
               state_next   = psl_pkg::ST_GAP;
               elapsed_next = 8'h00;
            end
         end
         psl_pkg::ST_GAP: begin
            if (dur_done) begin
               elapsed_next = 8'h00;
               if (bit_idx_reg == psl_pkg::LAST_BIT) begin
                  state_next = psl_pkg::ST_START;
               end else begin
                  state_next   = psl_pkg::ST_BIT;
                  bit_idx_next = bit_idx_reg + 3'h1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg   <= psl_pkg::ST_IDLE;
         elapsed_reg <= 8'h00;
         bit_idx_reg <= 3'h0;
      end else begin
         state_reg   <= state_next;
         elapsed_reg <= elapsed_next;
         bit_idx_reg <= bit_idx_next;
      end
   end

   // ==========================================================
   // external supply indicator
   psl_pkg::psl_lamp_t ext_next;

   assign ext_next.green  = !fault_reg && i_cond.adapter;
   assign ext_next.orange = fault_reg && (state_reg == psl_pkg::ST_BIT);

   // ==========================================================
   // output registers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_battery_lamp              <= '0;
         o_external_supply_indicator <= '0;
         o_fault_active              <= 1'b0;
         o_fault_code                <= 8'h00;
      end else begin
         o_battery_lamp              <= batt_next;
         o_external_supply_indicator <= ext_next;
         o_fault_active              <= fault_reg;
         o_fault_code                <= code_reg;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   // blinker phase decodes for the checks
   logic in_start;
   logic in_bit;
   logic in_gap;
   logic last_gap;

   assign in_start = (state_reg == psl_pkg::ST_START);
   assign in_bit   = (state_reg == psl_pkg::ST_BIT);
   assign in_gap   = (state_reg == psl_pkg::ST_GAP);
   assign last_gap = in_gap && dur_done && (bit_idx_reg == psl_pkg::LAST_BIT);

   AST_CHARGE_ORANGE: assert property (
      (i_cond.charging && i_cond.adapter)
      |=> (o_battery_lamp.orange && !o_battery_lamp.green))
      else $error("charging with adapter did not give steady orange");

   AST_FULL_GREEN: assert property (
      (i_cond.full && i_cond.adapter && !i_cond.charging)
      |=> (o_battery_lamp.green && !o_battery_lamp.orange))
      else $error("full charge with adapter did not give green");

   AST_LOW_BLINK: assert property (
      low_run |=> (!o_battery_lamp.green && o_battery_lamp.orange == $past(blink_on_reg)))
      else $error("low battery blink does not follow blink phase");

   AST_LOW_FLASH: assert property (
      low_press |=> (o_battery_lamp.orange == $past(flash_on) && !o_battery_lamp.green))
      else $error("low battery flash does not follow flash phase");

   AST_BATT_DARK: assert property (
      batt_dark |=> (o_battery_lamp == '0))
      else $error("battery lamp lit with no condition");

   AST_DC_GREEN: assert property (
      (!fault_reg && i_cond.adapter)
      |=> (o_external_supply_indicator.green && !o_external_supply_indicator.orange))
      else $error("adapter present without fault but supply lamp not green");

   AST_FAULT_NOT_GREEN: assert property (
      fault_reg |=> (!o_external_supply_indicator.green))
      else $error("supply lamp green during fault");

   AST_START_DARK: assert property (
      (state_reg == psl_pkg::ST_START) |=> !o_external_supply_indicator.orange)
      else $error("supply lamp lit during start marker");

   AST_LSB_FIRST: assert property (
      ($past(state_reg) == psl_pkg::ST_START && state_reg == psl_pkg::ST_BIT)
      |-> (bit_idx_reg == 3'h0))
      else $error("first bit shown is not bit zero");

   AST_BIT_WIDTH: assert property (
      (in_bit && dur_done)
      |-> (elapsed_reg + 8'h01 == (code_reg[bit_idx_reg] ? psl_pkg::ONE_TICKS
         : psl_pkg::ZERO_TICKS)))
      else $error("bit on time does not match bit value");

   AST_CODE_HELD: assert property (
      fault_reg |=> (fault_reg && code_reg == $past(code_reg)))
      else $error("latched fault code changed before reset");

   AST_BATT_ONE_COLOUR: assert property (
      o_battery_lamp.green |-> !o_battery_lamp.orange)
      else $error("battery lamp green and orange");

   AST_DC_DARK: assert property (
      (!fault_reg && !i_cond.adapter) |=> (o_external_supply_indicator == '0))
      else $error("supply lamp lit without adapter or fault");

   AST_NO_PRESS_ON_ADAPTER: assert property (
      (i_cond.adapter && !i_cond.charging && !i_cond.full && !low_run)
      |=> (o_battery_lamp == '0))
      else $error("battery lamp lit on adapter without charge state");

   AST_IDLE_NO_FAULT: assert property (
      !fault_reg |-> (state_reg == psl_pkg::ST_IDLE))
      else $error("blinker left idle without fault");

   AST_BIT_LIT: assert property (
      in_bit |=> o_external_supply_indicator.orange)
      else $error("supply lamp dark during a bit");

   AST_GAP_DARK: assert property (
      in_gap |=> !o_external_supply_indicator.orange)
      else $error("supply lamp lit in bit gap");

   AST_NEXT_BIT: assert property (
      (in_gap && dur_done && !last_gap)
      |=> (in_bit && bit_idx_reg == $past(bit_idx_reg) + 3'h1))
      else $error("bits not shown in ascending order");

   AST_FRAME_REPEAT: assert property (
      last_gap |=> in_start)
      else $error("pattern did not restart after last bit");

   AST_START_HOLD: assert property (
      (in_start && !dur_done) |=> in_start)
      else $error("start marker ended early");

   AST_DUR_BOUND: assert property (
      (state_reg != psl_pkg::ST_IDLE) |-> (elapsed_reg < dur_target))
      else $error("phase ran past its length");

   AST_LATCH_FIRST: assert property (
      (!fault_reg && enc_valid) |=> (fault_reg && code_reg == $past(enc_code)))
      else $error("first fault code not latched");

   AST_FAULT_OUT: assert property (
      fault_reg |=> (o_fault_active && o_fault_code == $past(code_reg)))
      else $error("fault status outputs do not show latch");

   AST_CLEAR_OUT: assert property (
      !fault_reg |=> (!o_fault_active && o_fault_code == '0))
      else $error("fault status shown without fault");

   AST_BLINK_RANGE: assert property (
      blink_cnt_reg < psl_pkg::BLINK_TICKS)
      else $error("blink counter out of range");

   AST_FLASH_RANGE: assert property (
      flash_cnt_reg < psl_pkg::FLASH_PERIOD_TICKS)
      else $error("flash counter out of range");

   COV_FAULT_LATCH: cover property (!fault_reg ##1 fault_reg);
   COV_REPEAT: cover property (state_reg == psl_pkg::ST_GAP ##1 state_reg == psl_pkg::ST_START);
   COV_LOW_BLINK: cover property (low_run && blink_on_reg);
   COV_FLASH: cover property (low_press && flash_on);
   COV_LAST_BIT: cover property (last_gap);

endmodule

// file: core/psl_tick_timer.sv
// timebase: one-cycle tick every CYCLES clocks
`timescale 1ns/100ps
module psl_tick_timer #(
   parameter int CYCLES = psl_pkg::TICK_CYCLES
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   output logic      o_tick
);
   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_reg;
   logic          wrap;

   assign wrap = (cnt_reg == LAST);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= '0;
         o_tick  <= 1'b0;
      end else begin
         cnt_reg <= wrap ? '0 : cnt_reg + CW'(1);
         o_tick  <= wrap;
      end
   end
endmodule

// file: tb/psl_lamp_observer.sv
// partner model: service technician decoding the supply lamp blink pattern
`timescale 1ns/100ps
module psl_lamp_observer #(
   parameter int TICK = 4
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic       i_lamp,
   output logic            o_done,
   output logic [7:0]      o_code,
   output logic [7:0]      o_bad
);
   // ==========================================================
   // run length of the current lamp level
   logic       lamp_reg;
   int         run_reg;
   logic [3:0] nbits_reg;
   logic [7:0] frames_reg;
   logic       len_one;
   logic       len_zero;
   logic       len_gap;
   logic       len_start;
   logic       is_start;

   assign len_one   = (run_reg >= 9 * TICK - 2) && (run_reg <= 10 * TICK + 2);
   assign len_zero  = (run_reg >= 4 * TICK - 2) && (run_reg <= 5 * TICK + 2);
   assign len_gap   = (run_reg >= 4 * TICK - 2) && (run_reg <= 5 * TICK + 2);
   assign is_start  = (run_reg >= 15 * TICK);
   assign len_start = (run_reg >= 20 * TICK - 2) && (run_reg <= 25 * TICK + 2);

   // ==========================================================
   // decoder
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         lamp_reg   <= 1'b0;
         run_reg    <= 0;
         nbits_reg  <= 4'hF;
         frames_reg <= 8'h00;
         o_done     <= 1'b0;
         o_code     <= 8'h00;
         o_bad      <= 8'h00;
      end else begin
         lamp_reg <= i_lamp;
         o_done   <= 1'b0;
         run_reg  <= (i_lamp != lamp_reg) ? 1 : run_reg + 1;
         if (lamp_reg && !i_lamp && nbits_reg < 4'h8) begin
            o_code    <= {len_one, o_code[7:1]};
            nbits_reg <= nbits_reg + 4'h1;
            if (!len_one && !len_zero) begin
               o_bad <= o_bad + 8'h01;
            end
            if (nbits_reg == 4'h7) begin
               o_done     <= 1'b1;
               frames_reg <= frames_reg + 8'h01;
            end
         end
         if (!lamp_reg && i_lamp) begin
            if (is_start) begin
               nbits_reg <= 4'h0;
               if (frames_reg != 8'h00 && !len_start) begin
                  o_bad <= o_bad + 8'h01;
               end
            end else if (!len_gap || nbits_reg >= 4'h8) begin
               o_bad <= o_bad + 8'h01;
            end
         end
      end
   end
endmodule

// file: tb/psl_status_lamps_tb.sv
// self-checking testbench for the status lamp block
`timescale 1ns/100ps
module psl_status_lamps_tb;
   localparam int T = 4;
   logic                      clk;
   logic                      rst;
   psl_pkg::psl_cond_t        cond;
   psl_pkg::psl_fault_flags_t faults;
   psl_pkg::psl_lamp_t        batt;
   psl_pkg::psl_lamp_t        sup;
   logic                      fault_active;
   logic [7:0]                fault_code;
   logic                      obs_done;
   logic [7:0]                obs_code;
   logic [7:0]                obs_bad;
   int                        mismatches;
   int                        checks_done;
   int                        cycles;

   psl_status_lamps #(.TICK_CYCLES(T)) dut_u (
      .i_ref_clk                   (clk),
      .i_rst                       (rst),
      .i_cond                      (cond),
      .i_faults                    (faults),
      .o_battery_lamp              (batt),
      .o_external_supply_indicator (sup),
      .o_fault_active              (fault_active),
      .o_fault_code                (fault_code)
   );

   psl_lamp_observer #(.TICK(T)) obs_u (
      .i_ref_clk (clk),
      .i_rst     (rst),
      .i_lamp    (sup.orange),
      .o_done    (obs_done),
      .o_code    (obs_code),
      .o_bad     (obs_bad)
   );

   // ==========================================================
   // clock, reset values and watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 60000) begin
         mismatches = mismatches + 1;
         tally_and_finish();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic check_range(input int got, input int lo, input int hi, input string what);
      checks_done = checks_done + 1;
      if (got < lo || got > hi) begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
      end
   endtask

   task automatic do_reset();
      @(negedge clk);
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
   endtask

   task automatic wait_lamp(input logic lvl, output int n);
      n = 0;
      while (batt.orange !== lvl && n < 60 * T) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic measure(output int on_c, output int off_c);
      int d;
      wait_lamp(1'b1, d);
      wait_lamp(1'b0, d);
      wait_lamp(1'b1, d);
      wait_lamp(1'b0, on_c);
      wait_lamp(1'b1, off_c);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      @(negedge clk);
      while (obs_done !== 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      check_range(n, 0, 999, "frame wait");
   endtask

   // ==========================================================
   // scenarios
   task automatic test_steady();
      logic [5:0] cv [6] = '{6'h25, 6'h21, 6'h11, 6'h15, 6'h07, 6'h20};
      logic [1:0] ev [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
      for (int k = 0; k < 6; k++) begin
         @(negedge clk);
         cond = psl_pkg::psl_cond_t'(cv[k]);
         repeat (3) @(negedge clk);
         check_bits({6'h00, batt}, {6'h00, ev[k]}, "battery lamp");
         check_bits({6'h00, sup}, {6'h00, cv[k][0], 1'b0}, "supply lamp");
         repeat (12 * T) @(negedge clk);
         check_bits({6'h00, batt}, {6'h00, ev[k]}, "battery steady");
      end
      $display("test_steady done");
   endtask

   task automatic test_blink();
      int on_c;
      int off_c;
      @(negedge clk);
      cond = psl_pkg::psl_cond_t'(6'h0C);
      measure(on_c, off_c);
      check_range(on_c, 5 * T - 1, 5 * T + 1, "blink on");
      check_range(off_c, 5 * T - 1, 5 * T + 1, "blink off");
      check_bits({7'h00, batt.green}, 8'h00, "blink green");
      $display("test_blink done");
   endtask

   task automatic test_flash();
      int on_c;
      int off_c;
      @(negedge clk);
      cond = psl_pkg::psl_cond_t'(6'h0A);
      measure(on_c, off_c);
      check_range(on_c, T - 1, T + 1, "flash on");
      check_range(on_c + off_c, 10 * T - 1, 10 * T + 1, "flash period");
      check_bits({6'h00, sup}, 8'h00, "supply dark");
      $display("test_flash done");
   endtask

   task automatic test_codes();
      logic [7:0] base [10] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50,
                                8'h60, 8'h70, 8'h80, 8'h90, 8'hA0};
      int         wid  [10] = '{5, 6, 6, 2, 6, 6, 4, 4, 5, 5};
      int         off  [10] = '{44, 38, 32, 30, 24, 18, 14, 10, 5, 0};
      logic [7:0] exp;
      for (int g = 0; g < 10; g++) begin
         for (int i = 0; i < wid[g]; i++) begin
            exp = (g == 3 && i == 1) ? 8'h45 : base[g] + 8'(i);
            faults = '0;
            cond = psl_pkg::psl_cond_t'(6'h01);
            do_reset();
            repeat (3) @(negedge clk);
            check_bits({6'h00, sup}, 8'h02, "green before fault");
            faults[off[g] + i] = 1'b1;
            wait_done();
            check_bits(obs_code, exp, "blinked code");
            check_bits(obs_bad, 8'h00, "frame timing");
            check_bits(fault_code, exp, "code table");
            check_bits({7'h00, sup.green}, 8'h00, "green in fault");
            check_bits({7'h00, fault_active}, 8'h01, "fault flag");
         end
      end
      $display("test_codes done");
   endtask

   task automatic test_latch_repeat();
      faults = '0;
      do_reset();
      @(negedge clk);
      faults[4] = 1'b1;
      faults[39] = 1'b1;
      wait_done();
      check_bits(obs_code, 8'h21, "lowest code wins");
      faults[44] = 1'b1;
      wait_done();
      check_bits(obs_code, 8'h21, "repeated frame");
      check_bits(fault_code, 8'h21, "code held");
      check_bits(obs_bad, 8'h00, "pattern timing");
      faults = '0;
      do_reset();
      repeat (3) @(negedge clk);
      check_bits(fault_code, 8'h00, "code cleared");
      check_bits({7'h00, fault_active}, 8'h00, "flag cleared");
      $display("test_latch_repeat done");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      rst = 1'b1;
      cond = '0;
      faults = '0;
      mismatches = 0;
      checks_done = 0;
      cycles = 0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      test_steady();
      test_blink();
      test_flash();
      test_codes();
      test_latch_repeat();
      tally_and_finish();
   end
endmodule
